// ===== rtl/bmq_top.sv
// Block memory with write behaviours and queue mode, two-entry output buffer
`timescale 1ns/10ps
//
// Contract
// - Normal write puts nothing on the output
// - Write-through returns the written word
// - Read-before-write returns the old contents
// - Queue has separate push and pull controls
// - Queue makes four occupancy flags
// - Saturated flags registered on the push side
// - Vacant flags registered on the pull side
// - Thresholds clamped to their legal ranges
// - Global reset clears pointers and saturated flags, sets vacant flags
// - Pointer clear resets only the pull pointer
// - Cascade inputs act as select bit two
// - Push side select gates every push
module bmq_top
  import bmq_pkg::*;
#(
  parameter int AW = bmq_pkg::BMQ_ADDR_W,
  parameter int DW = bmq_pkg::BMQ_DATA_W,
  parameter int LW = bmq_pkg::BMQ_LANE_W
) (
  input  wire logic                CLK,                  // Core clock
  input  wire logic                RST,                  // Sync reset, high
  input  wire logic                QUEUE_MODE,           // 1: queue, 0: RAM
  input  wire bmq_pkg::bmq_wmode_t WR_BEHAV,             // RAM write mode
  input  wire logic                RAM_CLOCK_GATE,       // RAM access gate
  input  wire logic                RAM_SELECT,           // RAM select
  input  wire logic                RAM_WRITE,            // RAM write strobe
  input  wire logic [AW-1:0]       RAM_ADDR,             // RAM address
  input  wire logic [DW-1:0]       RAM_DATA_IN,          // RAM write word
  input  wire logic [DW/LW-1:0]    LANE_MASK,            // RAM lane mask
  input  wire logic                PUSH_CLOCK_GATE,      // Push gate
  input  wire logic [1:0]          PUSH_SIDE_SELECT,     // Push select 1:0
  input  wire logic                SATURATED_CASCADE_IN, // Push select 2
  input  wire logic                PUSH_STROBE,          // Push strobe
  input  wire logic [DW-1:0]       PUSH_DATA,            // Push word
  input  wire logic                PULL_CLOCK_GATE,      // Pull gate
  input  wire logic [1:0]          PULL_SIDE_SELECT,     // Pull select 1:0
  input  wire logic                VACANT_CASCADE_IN,    // Pull select 2
  input  wire logic                PULL_STROBE,          // Pull strobe
  input  wire logic                PULL_POINTER_CLEAR,   // Pull pointer reset
  input  wire logic [AW-1:0]       SAT_LEVEL,            // Saturated level
  input  wire logic [AW-1:0]       NEAR_SAT_LEVEL,       // Nearly sat level
  input  wire logic [AW-1:0]       NEAR_VAC_LEVEL,       // Nearly vacant lvl
  input  wire logic                OUT_READY,            // Receiver ready
  output logic                     OUT_VALID,            // Output word valid
  output logic      [DW-1:0]       OUT_DATA,             // Output word
  output logic                     LOAD_READY,           // Room for a fetch
  output logic                     QUEUE_SATURATED_FLAG,        // Saturated
  output logic                     QUEUE_NEARLY_SATURATED_FLAG, // Near sat
  output logic                     QUEUE_VACANT_FLAG,           // Vacant
  output logic                     QUEUE_NEARLY_VACANT_FLAG     // Near vac
);

  // Whole module state
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic          sat;
    logic          nsat;
    logic          vac;
    logic          nvac;
    logic          inflight;
    logic          wt_sel;
    logic [DW-1:0] wt_data;
    logic [DW-1:0] b0;
    logic [DW-1:0] b1;
    logic [1:0]    cnt;
    logic          vld;
    logic          room;
  } bmq_state_t;

  bmq_state_t    st_r;
  bmq_state_t    st_nxt;
  logic [AW-1:0] occ;
  logic [AW-1:0] occ_nxt;
  logic [AW-1:0] sat_lvl;
  logic [AW-1:0] nsat_lvl;
  logic [AW-1:0] nvac_lvl;
  logic          push_go;
  logic          pull_go;
  logic          ram_go;
  logic          ram_out;
  logic          mem_wr;
  logic          mem_rd;
  logic [AW-1:0] mem_waddr;
  logic [AW-1:0] mem_raddr;
  logic [DW-1:0] mem_wdata;
  logic [DW/LW-1:0] mem_lane;
  logic [DW-1:0] mem_q;
  logic [DW-1:0] in_word;

  // Thresholds held inside their legal ranges
  always_comb
  begin
    sat_lvl  = (SAT_LEVEL == '0) ? AW'(1) : SAT_LEVEL;
    nsat_lvl = (NEAR_SAT_LEVEL == '0) ? AW'(1) : NEAR_SAT_LEVEL;
    if (nsat_lvl >= sat_lvl)
      nsat_lvl = AW'(sat_lvl - 1'b1);
    nvac_lvl = (NEAR_VAC_LEVEL == '0) ? AW'(1) : NEAR_VAC_LEVEL;
    if (nvac_lvl >= sat_lvl)
      nvac_lvl = AW'(sat_lvl - 1'b1);
  end

  // Accepted accesses, all controls active high
  assign occ     = AW'(st_r.wr_ptr - st_r.rd_ptr);
  assign push_go = QUEUE_MODE && PUSH_CLOCK_GATE && (&PUSH_SIDE_SELECT)
                   && SATURATED_CASCADE_IN && PUSH_STROBE
                   && !st_r.sat;
  assign pull_go = QUEUE_MODE && PULL_CLOCK_GATE && (&PULL_SIDE_SELECT)
                   && VACANT_CASCADE_IN && PULL_STROBE
                   && !st_r.vac && st_r.room;
  assign ram_out = !RAM_WRITE || (WR_BEHAV != BMQ_NORMAL);
  assign ram_go  = !QUEUE_MODE && RAM_CLOCK_GATE && RAM_SELECT
                   && (st_r.room || !ram_out);

  // Storage port steering
  assign mem_wr    = push_go || (ram_go && RAM_WRITE);
  assign mem_rd    = pull_go || (ram_go && !RAM_WRITE)
                     || (ram_go && WR_BEHAV == BMQ_RBW);
  assign mem_waddr = QUEUE_MODE ? st_r.wr_ptr : RAM_ADDR;
  assign mem_raddr = QUEUE_MODE ? st_r.rd_ptr : RAM_ADDR;
  assign mem_wdata = QUEUE_MODE ? PUSH_DATA : RAM_DATA_IN;
  assign mem_lane  = QUEUE_MODE ? '1 : LANE_MASK;
  assign in_word   = st_r.wt_sel ? st_r.wt_data : mem_q;

  bmq_mem #(
    .AW (AW),
    .DW (DW),
    .LW (LW)
  ) u_mem (
    .clk     (CLK),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .wr_lane (mem_lane),
    .rd_en   (mem_rd),
    .rd_addr (mem_raddr),
    .rd_data (mem_q)
  );

  // Next state: pointers, flags, fetch tracking and output buffer
  always_comb
  begin
    logic [1:0] c;
    logic [2:0] fill;
    c      = st_r.cnt;
    fill   = '0;
    st_nxt = st_r;
    if (push_go)
      st_nxt.wr_ptr = AW'(st_r.wr_ptr + 1'b1);
    if (pull_go)
      st_nxt.rd_ptr = AW'(st_r.rd_ptr + 1'b1);
    if (QUEUE_MODE && PULL_POINTER_CLEAR)
      st_nxt.rd_ptr = '0;
    occ_nxt        = AW'(st_nxt.wr_ptr - st_nxt.rd_ptr);
    st_nxt.sat     = (occ_nxt >= sat_lvl);
    st_nxt.nsat    = (occ_nxt >= nsat_lvl);
    st_nxt.vac     = (occ_nxt == '0);
    st_nxt.nvac    = (occ_nxt <= nvac_lvl);
    st_nxt.inflight = pull_go || (ram_go && ram_out);
    st_nxt.wt_sel  = ram_go && RAM_WRITE
                     && (WR_BEHAV == BMQ_THROUGH);
    st_nxt.wt_data = RAM_DATA_IN;
    // Buffer: pop the head, then append the arriving word
    if (st_r.vld && OUT_READY)
    begin
      st_nxt.b0 = st_r.b1;
      c = 2'(c - 1'b1);
    end
    if (st_r.inflight)
    begin
      if (c == 2'h0)
        st_nxt.b0 = in_word;
      else
        st_nxt.b1 = in_word;
      c = 2'(c + 1'b1);
    end
    st_nxt.cnt  = c;
    st_nxt.vld  = (c != 2'h0);
    fill        = {1'b0, c} + {2'b00, st_nxt.inflight};
    st_nxt.room = (fill < {1'b0, BMQ_BUF_DEPTH});
  end

  // State register with global reset
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_r        <= '0;
      st_r.sat    <= BMQ_SAT_RST;
      st_r.nsat   <= BMQ_NSAT_RST;
      st_r.vac    <= BMQ_VAC_RST;
      st_r.nvac   <= BMQ_NVAC_RST;
      st_r.room   <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign OUT_VALID                   = st_r.vld;
  assign OUT_DATA                    = st_r.b0;
  assign LOAD_READY                  = st_r.room;
  assign QUEUE_SATURATED_FLAG        = st_r.sat;
  assign QUEUE_NEARLY_SATURATED_FLAG = st_r.nsat;
  assign QUEUE_VACANT_FLAG           = st_r.vac;
  assign QUEUE_NEARLY_VACANT_FLAG    = st_r.nvac;

  // Checks of the guarded behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_normal_silent;
    ram_go && RAM_WRITE && WR_BEHAV == BMQ_NORMAL |=> !st_r.inflight;
  endproperty
  a_normal_silent: assert property (p_normal_silent)
    else $error("normal write produced output");

  property p_through_copy;
    ram_go && RAM_WRITE && WR_BEHAV == BMQ_THROUGH |=>
      st_r.wt_sel && st_r.wt_data == $past(RAM_DATA_IN) ##1
      st_r.vld;
  endproperty
  a_through_copy: assert property (p_through_copy)
    else $error("write-through word not returned");

  property p_rbw_old;
    ram_go && RAM_WRITE && WR_BEHAV == BMQ_RBW |=>
      st_r.inflight && !st_r.wt_sel;
  endproperty
  a_rbw_old: assert property (p_rbw_old)
    else $error("read-before-write did not fetch");

  property p_sat_flag;
    $stable(SAT_LEVEL) |-> st_r.sat == (occ >= sat_lvl);
  endproperty
  a_sat_flag: assert property (p_sat_flag)
    else $error("saturated flag disagrees with occupancy");

  property p_vac_flag;
    st_r.vac == (occ == '0);
  endproperty
  a_vac_flag: assert property (p_vac_flag)
    else $error("vacant flag disagrees with occupancy");

  property p_ptr_clear;
    QUEUE_MODE && PULL_POINTER_CLEAR |=> st_r.rd_ptr == '0 &&
      st_r.wr_ptr == AW'($past(st_r.wr_ptr) + $past(push_go));
  endproperty
  a_ptr_clear: assert property (p_ptr_clear)
    else $error("pointer clear wrong");

  property p_cascade;
    QUEUE_MODE && !SATURATED_CASCADE_IN |=> $stable(st_r.wr_ptr);
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("push taken while deselected");

  property p_push_step;
    push_go |=> st_r.wr_ptr == AW'($past(st_r.wr_ptr) + 1'b1);
  endproperty
  a_push_step: assert property (p_push_step)
    else $error("push pointer did not advance");

  property p_hold;
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output word lost under stall");

  property p_no_push_sat;
    st_r.sat |=> $stable(st_r.wr_ptr);
  endproperty
  a_no_push_sat: assert property (p_no_push_sat)
    else $error("push taken while saturated");

  c_push:  cover property (push_go ##1 push_go);
  c_pull:  cover property (pull_go ##2 OUT_VALID && OUT_READY);
  c_wt:    cover property (st_r.wt_sel ##1 OUT_VALID);
  c_clear: cover property (PULL_POINTER_CLEAR && !st_r.vac);

endmodule : bmq_top

// ===== common/bmq_pkg.sv
// Shared constants and types for the block memory with queue mode
package bmq_pkg;

  // Default geometry
  localparam int BMQ_ADDR_W = 9;
  localparam int BMQ_DATA_W = 16;
  localparam int BMQ_LANE_W = 8;

  // Flag values while and right after the global reset
  localparam logic BMQ_SAT_RST  = 1'b0;
  localparam logic BMQ_NSAT_RST = 1'b0;
  localparam logic BMQ_VAC_RST  = 1'b1;
  localparam logic BMQ_NVAC_RST = 1'b1;

  // Depth of the output buffer
  localparam logic [1:0] BMQ_BUF_DEPTH = 2'h2;

  // Write behaviour of the plain memory port
  typedef enum logic [1:0] {
    BMQ_NORMAL  = 2'h0,
    BMQ_THROUGH = 2'h1,
    BMQ_RBW     = 2'h3
  } bmq_wmode_t;

endpackage : bmq_pkg

// ===== rtl/bmq_mem.sv
// Dual-address storage array with lane mask and registered read data
`timescale 1ns/10ps
module bmq_mem #(
  parameter int AW = 9,
  parameter int DW = 16,
  parameter int LW = 8
) (
  input  wire logic          clk,     // Core clock
  input  wire logic          wr_en,   // Store strobe
  input  wire logic [AW-1:0] wr_addr, // Store address
  input  wire logic [DW-1:0] wr_data, // Store word
  input  wire logic [DW/LW-1:0] wr_lane, // Lanes to store
  input  wire logic          rd_en,   // Fetch strobe
  input  wire logic [AW-1:0] rd_addr, // Fetch address
  output logic      [DW-1:0] rd_data  // Fetched word, registered
);

  // One array per lane; a fetch of the stored address sees old data
  for (genvar g = 0; g < DW / LW; g++)
  begin : g_lane
    logic [LW-1:0] cells [2**AW];
    logic [LW-1:0] q_r;

    always_ff @(posedge clk)
    begin
      if (wr_en && wr_lane[g])
        cells[wr_addr] <= wr_data[g*LW +: LW];
      if (rd_en)
        q_r <= cells[rd_addr];
    end

    // Each lane owns its slice of the read word
    assign rd_data[g*LW +: LW] = q_r;
  end

endmodule : bmq_mem

// ===== dv/bmq_sink.sv
// Receiver model for the output buffer: stalls on demand, keeps words
`timescale 1ns/10ps
module bmq_sink (
  input  wire logic        clk,   // Core clock
  input  wire logic        rst,   // Sync reset, high
  input  wire logic        stall, // Refuse words while high
  input  wire logic        vld,   // Word offered
  input  wire logic [15:0] dat,   // Offered word
  output logic             rdy    // Taking words
);
  logic [15:0] got [$];
  logic        ph_r = 1'b0;
  logic        rdy_r = 1'b0;
  assign rdy = rdy_r;
  // Slow taker: ready every other cycle, none under stall or reset
  always @(posedge clk)
  begin
    if (vld && rdy_r)
      got.push_back(dat);
    ph_r  <= rst ? 1'b0 : ~ph_r;
    rdy_r <= !rst && !stall && ph_r;
  end
endmodule : bmq_sink

// ===== dv/tb_top.sv
// Bench top: RAM and queue accesses with expected words and flags
`timescale 1ns/10ps
module tb_top;
  import bmq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, qmode = 1'b0, stall = 1'b0;
  bmq_wmode_t behav = BMQ_NORMAL;
  logic rgate = 1'b0, rsel = 1'b0, rwr = 1'b0, pstb = 1'b0, scas = 1'b1;
  logic [8:0] raddr = 9'h000;
  logic [15:0] rdin = 16'h0000, pdat = 16'h0000;
  logic [1:0] lmask = 2'h3;
  logic pgate = 1'b1, qgate = 1'b1, vcas = 1'b1, qstb = 1'b0, pclr = 1'b0;
  logic [1:0] psel = 2'h3, qsel = 2'h3;
  logic [8:0] sat_l = 9'h004, nsat_l = 9'h003, nvac_l = 9'h001;
  logic ordy, ovld, lrdy, fs, fns, fv, fnv;
  logic [15:0] odat;
  logic [3:0] pf [6] = '{4'h3, 4'h1, 4'h0, 4'h4, 4'hc, 4'hc};
  int fails = 0, num_checks = 0;

  // Clock
  always #50 clk = ~clk;

  bmq_top dut (.CLK(clk), .RST(rst), .QUEUE_MODE(qmode), .WR_BEHAV(behav),
    .RAM_CLOCK_GATE(rgate), .RAM_SELECT(rsel), .RAM_WRITE(rwr),
    .RAM_ADDR(raddr), .RAM_DATA_IN(rdin), .LANE_MASK(lmask),
    .PUSH_CLOCK_GATE(pgate), .PUSH_SIDE_SELECT(psel),
    .SATURATED_CASCADE_IN(scas), .PUSH_STROBE(pstb), .PUSH_DATA(pdat),
    .PULL_CLOCK_GATE(qgate), .PULL_SIDE_SELECT(qsel),
    .VACANT_CASCADE_IN(vcas), .PULL_STROBE(qstb),
    .PULL_POINTER_CLEAR(pclr), .SAT_LEVEL(sat_l), .NEAR_SAT_LEVEL(nsat_l),
    .NEAR_VAC_LEVEL(nvac_l), .OUT_READY(ordy), .OUT_VALID(ovld),
    .OUT_DATA(odat), .LOAD_READY(lrdy), .QUEUE_SATURATED_FLAG(fs),
    .QUEUE_NEARLY_SATURATED_FLAG(fns), .QUEUE_VACANT_FLAG(fv),
    .QUEUE_NEARLY_VACANT_FLAG(fnv));

  bmq_sink sink (.clk(clk), .rst(rst), .stall(stall), .vld(ovld),
    .dat(odat), .rdy(ordy));

  task automatic chk_word(input string s, input logic [15:0] e,
                          input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk_word

  task automatic chk_flags(input string s, input logic [3:0] e);
    num_checks++;
    if ({fs, fns, fv, fnv} !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", s, e, {fs, fns, fv, fnv});
    end
  endtask : chk_flags

  // Holds the request until an edge that finds LOAD_READY high
  task automatic ram(input bmq_wmode_t m, input logic w,
                     input logic [8:0] a, input logic [15:0] d,
                     input logic [1:0] k);
    int n;
    n = 0;
    @(posedge clk);
    behav <= m;
    rwr <= w;
    raddr <= a;
    rdin <= d;
    lmask <= k;
    rgate <= 1'b1;
    rsel <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (lrdy !== 1'b1 && n < 50);
    chk_word("ram_taken", 16'h1, {15'h0, lrdy});
    rgate <= 1'b0;
    rsel <= 1'b0;
  endtask : ram

  task automatic push(input logic [15:0] d, input logic c);
    @(posedge clk);
    pdat <= d;
    scas <= c;
    pstb <= 1'b1;
    @(posedge clk);
    pstb <= 1'b0;
    #1;
  endtask : push

  task automatic pull;
    int n;
    n = 0;
    @(posedge clk);
    qstb <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (lrdy !== 1'b1 && n < 50);
    chk_word("pull_taken", 16'h1, {15'h0, lrdy});
    qstb <= 1'b0;
  endtask : pull

  // Waits for the receiver to hold a word, then compares it
  task automatic take(input logic [15:0] e);
    int n;
    n = 0;
    while (sink.got.size() == 0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    chk_word("out_data", e, sink.got.size() ? sink.got.pop_front() : 'x);
  endtask : take

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    summarize();
  end

  // Test sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_flags("reset_flags", 4'h3);
    chk_word("load_ready", 16'h1, {15'h0, lrdy});
    ram(BMQ_NORMAL, 1'b1, 9'h005, 16'h1234, 2'h3);
    repeat (6) @(posedge clk);
    chk_word("normal_out", 16'h0, 16'(sink.got.size()));
    ram(BMQ_NORMAL, 1'b0, 9'h005, 16'h0000, 2'h3);
    take(16'h1234);
    ram(BMQ_THROUGH, 1'b1, 9'h006, 16'habcd, 2'h3);
    take(16'habcd);
    ram(BMQ_RBW, 1'b1, 9'h005, 16'h5555, 2'h3);
    take(16'h1234);
    ram(BMQ_NORMAL, 1'b1, 9'h006, 16'hffff, 2'h1);
    ram(BMQ_NORMAL, 1'b0, 9'h005, 16'h0000, 2'h3);
    take(16'h5555);
    ram(BMQ_NORMAL, 1'b0, 9'h006, 16'h0000, 2'h3);
    take(16'habff);
    $display("test ram done");
    qmode <= 1'b1;
    push(16'h0001, 1'b0);
    chk_flags("cascade_off", 4'h3);
    for (int i = 1; i <= 5; i++)
    begin
      push(16'(i * 16'h11), 1'b1);
      chk_flags("push_flags", pf[i]);
    end
    @(posedge clk);
    stall <= 1'b1;
    pull();
    pull();
    repeat (8) @(posedge clk);
    #1;
    chk_word("hold_valid", 16'h1, {15'h0, ovld});
    chk_word("hold_data", 16'h0011, odat);
    @(posedge clk);
    stall <= 1'b0;
    pull();
    pull();
    for (int i = 1; i <= 4; i++)
      take(16'(i * 16'h11));
    chk_flags("drained", 4'h3);
    @(posedge clk);
    pclr <= 1'b1;
    @(posedge clk);
    pclr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_flags("ptr_clear", 4'hc);
    // Pulls with the cascade input or the gate low must be refused
    @(posedge clk);
    vcas <= 1'b0;
    pull();
    vcas <= 1'b1;
    qgate <= 1'b0;
    pull();
    qgate <= 1'b1;
    #1;
    chk_flags("pull_gated", 4'hc);
    pull();
    take(16'h0011);
    $display("test queue done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_flags("rerun_reset", 4'h3);
    chk_word("rerun_valid", 16'h0, {15'h0, ovld});
    $display("test reset done");
    summarize();
  end
endmodule : tb_top
